// ### hw/hir_router.sv
`timescale 1ns/1ns
`include "hir_defines.svh"
// Behaviour
// - APIC space is uncached; each write passes alone, never merged.
// - Decode FEC0_0000..FECF_FFFF as the path to downstream I/O APICs.
// - I/O APIC ranges are fixed constants; software cannot move them.
// - End-of-interrupt from a processor is broadcast to every port whose disable bit is clear.
// - Interrupt acknowledge cycle goes to compatibility hub; returned data is vector.
// - Writes to I/O APIC range go out the port its fixed map selects.
// - Interrupt messages never pass posted write data held in the hub; only inbound ones wait here, and only on the memory stage.
// - Accept legacy assert/deassert messages from downstream ports.
// - Claim processor bus interrupts with target ready and no-data response.
// - Directed interrupts complete normally, forwarded to the other buses.
// - Redirectable: new message, hint cleared, chosen ID, all four buses.
// - Directed broadcast ID all ones goes to the other buses.
// - Never defer nor retry; every interrupt is accepted.
// - Without resources hold priority bus request until they free.
// - Physical redirectable with enabled APIC ID: clear hint, all buses.
// - End-of-interrupt reaches a port only if its disable bit is clear.
// - End-of-interrupt leaves each port whose disable bit is clear as an end-of-interrupt message.
module hir_router
	import hir_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic          ce,
	input  wire logic          fsb_req_valid,
	input  wire hir_fsb_req_t  fsb_req,
	output logic               target_ready_n,
	output logic               no_data_resp,
	output logic               priority_bus_request_n,
	output logic               fsb_data_valid,
	output logic [7:0]         fsb_data,
	input  wire logic [31:0]   apic_id_enabled,
	input  wire logic [7:0]    redir_choice_id,
	output logic               int_msg_valid,
	output hir_int_msg_t       int_msg,
	input  wire logic          int_msg_ready,
	input  wire logic          ib_wr_valid,
	input  wire hir_ib_wr_t    ib_wr,
	output logic               ib_wr_ready,
	output logic               mem_wr_valid,
	output hir_ib_wr_t         mem_wr,
	input  wire logic          mem_wr_ready,
	output logic               apic_wr_valid,
	output hir_ib_wr_t         apic_wr,
	input  wire logic          apic_wr_ready,
	input  wire logic [3:0]    port_eoi_disable,
	output logic [3:0]         eoi_msg_valid,
	output logic [7:0]         eoi_vector,
	output logic               interrupt_acknowledge_cycle,
	input  wire logic          iack_resp_valid,
	input  wire logic [7:0]    iack_resp_vector,
	input  wire logic          intx_valid,
	input  wire hir_intx_msg_t intx,
	output logic [3:0]         legacy_int_level
);

	// Inbound queue storage and pointers
	hir_ib_wr_t                q_mem [`HIR_Q_DEPTH];
	logic [`HIR_Q_AW-1:0]      wp_reg;
	logic [`HIR_Q_AW-1:0]      rp_reg;
	logic [`HIR_Q_CW-1:0]      cnt_reg;
	logic [`HIR_Q_CW-1:0]      cnt_next;
	hir_iack_st_t              iack_reg;
	logic [15:0]               intx_reg;
	hir_ib_wr_t                head;
	logic                      head_apic;
	logic                      head_int;
	logic                      push;
	logic                      pop;
	logic                      msg_free;
	logic                      mem_free;
	logic                      apic_free;
	logic                      fsb_take;
	logic                      fsb_can;
	logic                      ib_int_go;
	hir_int_msg_t              fsb_msg;
	hir_int_msg_t              ib_msg;

	// Window decode on fixed constants only, so nothing here is relocatable
	assign head      = q_mem[rp_reg];
	assign head_apic = (head.addr >= `HIR_IOAPIC_LO) && (head.addr <= `HIR_IOAPIC_HI);
	assign head_int  = (head.addr >= `HIR_INTMSG_LO) && (head.addr <= `HIR_INTMSG_HI);

	// Output stages free to load this cycle
	assign msg_free  = !int_msg_valid || int_msg_ready;
	assign mem_free  = !mem_wr_valid || mem_wr_ready;
	assign apic_free = !apic_wr_valid || apic_wr_ready;

	// A request is taken once; the cycle after a claim is skipped so a held
	// request is not counted twice while the processor sees target ready.
	assign fsb_can = fsb_req_valid && target_ready_n && (iack_reg == HIR_IACK_IDLE)
		&& !fsb_data_valid;
	always_comb begin
		case (fsb_req.kind)
			HIR_K_INT: fsb_take = fsb_can && msg_free;
			HIR_K_EOI: fsb_take = fsb_can;
			default:   fsb_take = 1'b0;
		endcase
	end

	// Routing of a processor-bus interrupt
	always_comb begin
		fsb_msg.hint      = fsb_req.hint;
		fsb_msg.dest_mode = fsb_req.dest_mode;
		fsb_msg.dest_id   = fsb_req.dest_id;
		fsb_msg.vector    = fsb_req.vector;
		fsb_msg.bus_mask  = `HIR_ALL_BUSES;
		if (!fsb_req.hint) begin
			// Directed, broadcast ID included: every bus but the source
			fsb_msg.bus_mask[fsb_req.src_bus] = 1'b0;
		end else if (!fsb_req.dest_mode && apic_id_enabled[fsb_req.dest_id[4:0]]) begin
			fsb_msg.hint = 1'b0;
		end else begin
			fsb_msg.hint    = 1'b0;
			fsb_msg.dest_id = redir_choice_id;
		end
	end

	// Routing of an inbound interrupt write; I/O sources go to all buses
	always_comb begin
		ib_msg.bus_mask  = `HIR_ALL_BUSES;
		ib_msg.hint      = head.addr[`HIR_ADDR_HINT];
		ib_msg.dest_mode = head.addr[`HIR_ADDR_DMODE];
		ib_msg.dest_id   = head.addr[`HIR_ADDR_DID_LSB +: 8];
		ib_msg.vector    = head.data[7:0];
		if (ib_msg.hint) begin
			ib_msg.hint = 1'b0;
			if (ib_msg.dest_mode || !apic_id_enabled[ib_msg.dest_id[4:0]]) begin
				ib_msg.dest_id = redir_choice_id;
			end
		end
	end

	// Head dispatch; an interrupt waits until the posted stage has drained
	assign ib_int_go = (cnt_reg != '0) && head_int && msg_free && !fsb_take
		&& !mem_wr_valid;
	always_comb begin
		pop = 1'b0;
		if (cnt_reg != '0) begin
			if (head_apic) begin
				pop = apic_free;
			end else if (head_int) begin
				pop = ib_int_go;
			end else begin
				pop = mem_free;
			end
		end
	end
	assign push     = ib_wr_valid && ib_wr_ready;
	assign cnt_next = cnt_reg + {{(`HIR_Q_CW-1){1'b0}}, push} - {{(`HIR_Q_CW-1){1'b0}}, pop};

	// One entry per doubleword write, so no two APIC writes are ever combined
	always_ff @(posedge clk) begin
		if (ce && push) begin
			q_mem[wp_reg] <= ib_wr;
		end
	end

	// Queue pointers, arrival order across all ports
	always_ff @(posedge clk) begin
		if (rst) begin
			wp_reg      <= '0;
			rp_reg      <= '0;
			cnt_reg     <= '0;
			ib_wr_ready <= 1'b0;
		end else if (ce) begin
			wp_reg      <= wp_reg + {{(`HIR_Q_AW-1){1'b0}}, push};
			rp_reg      <= rp_reg + {{(`HIR_Q_AW-1){1'b0}}, pop};
			cnt_reg     <= cnt_next;
			// Ready is registered; a slot is held back so it is never overrun
			ib_wr_ready <= (cnt_next < `HIR_Q_CW'(`HIR_Q_DEPTH - 1));
		end
	end

	// Posted memory write stage
	always_ff @(posedge clk) begin
		if (rst) begin
			mem_wr_valid <= 1'b0;
			mem_wr       <= '0;
		end else if (ce) begin
			if (pop && !head_apic && !head_int) begin
				mem_wr_valid <= 1'b1;
				mem_wr       <= head;
			end else if (mem_wr_ready) begin
				mem_wr_valid <= 1'b0;
			end
		end
	end

	// I/O APIC write stage; port picked by the fixed address map
	always_ff @(posedge clk) begin
		if (rst) begin
			apic_wr_valid <= 1'b0;
			apic_wr       <= '0;
		end else if (ce) begin
			if (pop && head_apic) begin
				apic_wr_valid <= 1'b1;
				apic_wr.addr  <= head.addr;
				apic_wr.data  <= head.data;
				apic_wr.port  <= head.addr[`HIR_IOAPIC_PORT_LSB +: 2];
			end else if (apic_wr_ready) begin
				apic_wr_valid <= 1'b0;
			end
		end
	end

	// Interrupt message stage; processor requests win over inbound ones
	always_ff @(posedge clk) begin
		if (rst) begin
			int_msg_valid <= 1'b0;
			int_msg       <= '0;
		end else if (ce) begin
			if (fsb_take && fsb_req.kind == HIR_K_INT) begin
				int_msg_valid <= 1'b1;
				int_msg       <= fsb_msg;
			end else if (ib_int_go) begin
				int_msg_valid <= 1'b1;
				int_msg       <= ib_msg;
			end else if (int_msg_ready) begin
				int_msg_valid <= 1'b0;
			end
		end
	end

	// Claim, stall and end-of-interrupt fan-out
	always_ff @(posedge clk) begin
		if (rst) begin
			target_ready_n         <= `HIR_RST_N_IDLE;
			no_data_resp           <= 1'b0;
			priority_bus_request_n <= `HIR_RST_N_IDLE;
			eoi_msg_valid          <= '0;
			eoi_vector             <= '0;
		end else if (ce) begin
			target_ready_n         <= !(fsb_take || (iack_reg == HIR_IACK_WAIT && iack_resp_valid));
			no_data_resp           <= fsb_take;
			// Stall new requests rather than retrying any interrupt that finds the message stage full
			priority_bus_request_n <= !(fsb_can && fsb_req.kind == HIR_K_INT && !msg_free);
			eoi_msg_valid          <= '0;
			if (fsb_take && fsb_req.kind == HIR_K_EOI) begin
				eoi_msg_valid <= ~port_eoi_disable;
				eoi_vector    <= fsb_req.vector;
			end
		end
	end

	// Interrupt acknowledge: ask the compatibility hub, return its vector
	always_ff @(posedge clk) begin
		if (rst) begin
			iack_reg                    <= HIR_IACK_IDLE;
			interrupt_acknowledge_cycle <= 1'b0;
			fsb_data_valid              <= 1'b0;
			fsb_data                    <= '0;
		end else if (ce) begin
			interrupt_acknowledge_cycle <= 1'b0;
			fsb_data_valid              <= 1'b0;
			case (iack_reg)
				HIR_IACK_IDLE: begin
					if (fsb_can && fsb_req.kind == HIR_K_IACK) begin
						interrupt_acknowledge_cycle <= 1'b1;
						iack_reg                    <= HIR_IACK_WAIT;
					end
				end
				HIR_IACK_WAIT: begin
					if (iack_resp_valid) begin
						fsb_data_valid <= 1'b1;
						fsb_data       <= iack_resp_vector;
						iack_reg       <= HIR_IACK_IDLE;
					end
				end
				default: iack_reg <= HIR_IACK_IDLE;
			endcase
		end
	end

	// Legacy wire levels: one bit per port and line, ORed per line.
	// Boot use only; these messages are slow next to message interrupts.
	always_ff @(posedge clk) begin
		if (rst) begin
			intx_reg         <= '0;
			legacy_int_level <= '0;
		end else if (ce) begin
			if (intx_valid) begin
				intx_reg[{intx.port, intx.line}] <= intx.assert_lvl;
			end
			for (int l = 0; l < 4; l++) begin
				legacy_int_level[l] <= intx_reg[l] | intx_reg[4 + l]
					| intx_reg[8 + l] | intx_reg[12 + l];
			end
		end
	end

endmodule

// ### pkg/hir_defines.svh
`ifndef HIR_DEFINES_SVH
`define HIR_DEFINES_SVH

// Fixed I/O APIC configuration window, never relocatable
`define HIR_IOAPIC_LO      32'hFEC0_0000
`define HIR_IOAPIC_HI      32'hFECF_FFFF
// Interrupt message window seen as inbound writes
`define HIR_INTMSG_LO     32'hFEE0_0000
`define HIR_INTMSG_HI     32'hFEEF_FFFF
// Fixed port selection inside the I/O APIC window
`define HIR_IOAPIC_PORT_LSB 12
// Field positions of an interrupt message address
`define HIR_ADDR_HINT     3
`define HIR_ADDR_DMODE    2
`define HIR_ADDR_DID_LSB  12
// Broadcast destination identifier
`define HIR_DID_BCAST     8'hFF
// Inbound posted write queue
`define HIR_Q_DEPTH       8
`define HIR_Q_AW          3
`define HIR_Q_CW          4
// All-buses mask and reset values
`define HIR_ALL_BUSES     4'hF
`define HIR_RST_N_IDLE    1'h1

`endif

// ### pkg/hir_pkg.sv
package hir_pkg;

	// Kind of transaction a processor bus presents
	typedef enum logic [1:0] {
		HIR_K_INT,
		HIR_K_EOI,
		HIR_K_IACK
	} hir_kind_t;

	// Processor bus interrupt-class request
	typedef struct packed {
		hir_kind_t   kind;
		logic [1:0]  src_bus;
		logic        hint;
		logic        dest_mode;
		logic [7:0]  dest_id;
		logic [7:0]  vector;
	} hir_fsb_req_t;

	// Inbound memory write from a downstream port (one doubleword)
	typedef struct packed {
		logic [1:0]  port;
		logic [31:0] addr;
		logic [31:0] data;
	} hir_ib_wr_t;

	// Interrupt message delivered to processor buses
	typedef struct packed {
		logic [3:0]  bus_mask;
		logic        hint;
		logic        dest_mode;
		logic [7:0]  dest_id;
		logic [7:0]  vector;
	} hir_int_msg_t;

	// Legacy assert/deassert message from a downstream port
	typedef struct packed {
		logic [1:0]  port;
		logic [1:0]  line;
		logic        assert_lvl;
	} hir_intx_msg_t;

	typedef enum logic {
		HIR_IACK_IDLE,
		HIR_IACK_WAIT
	} hir_iack_st_t;

endpackage

// ### sim/hir_router_properties.sv
`timescale 1ns/1ns
module hir_router_properties
	import hir_pkg::*;
(
	input wire logic         clk,
	input wire logic         rst,
	input wire logic         fsb_req_valid,
	input wire logic         target_ready_n,
	input wire logic         no_data_resp,
	input wire logic         priority_bus_request_n,
	input wire logic         fsb_data_valid,
	input wire logic         int_msg_valid,
	input wire hir_int_msg_t int_msg,
	input wire logic         int_msg_ready,
	input wire logic         mem_wr_valid,
	input wire hir_ib_wr_t   mem_wr,
	input wire logic         mem_wr_ready,
	input wire logic         apic_wr_valid,
	input wire hir_ib_wr_t   apic_wr,
	input wire logic [3:0]   port_eoi_disable,
	input wire logic [3:0]   eoi_msg_valid
);
	// One clock domain, so clock and reset are given once
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);

	chk_claim_nodata: assert property (
		no_data_resp |-> !target_ready_n && !fsb_data_valid)
		else $error("no-data response without claim");
	chk_eoi_mask: assert property (
		|eoi_msg_valid |-> eoi_msg_valid == ~$past(port_eoi_disable))
		else $error("eoi sent to a disabled port");
	chk_eoi_claim: assert property (
		|eoi_msg_valid |-> no_data_resp && !target_ready_n)
		else $error("eoi message without its claim");
	chk_msg_hold: assert property (
		int_msg_valid && !int_msg_ready |=> int_msg_valid && $stable(int_msg))
		else $error("interrupt message lost while stalled");
	chk_mem_hold: assert property (
		mem_wr_valid && !mem_wr_ready |=> mem_wr_valid && $stable(mem_wr))
		else $error("posted write changed while stalled");
	chk_apic_port: assert property (
		apic_wr_valid |-> apic_wr.addr[31:20] == 12'hFEC && apic_wr.port == apic_wr.addr[13:12])
		else $error("apic write on wrong port");
	// Inbound messages rise without a claim; posted data must have left first
	chk_int_nopass: assert property (
		$rose(int_msg_valid) && target_ready_n |-> !$past(mem_wr_valid))
		else $error("interrupt passed posted data");
	chk_prio_wait: assert property (
		!priority_bus_request_n |-> fsb_req_valid && target_ready_n)
		else $error("priority request without waiting interrupt");
endmodule

bind hir_router hir_router_properties u_hir_router_properties (.clk, .rst, .fsb_req_valid,
	.target_ready_n, .no_data_resp, .priority_bus_request_n, .fsb_data_valid, .int_msg_valid,
	.int_msg, .int_msg_ready, .mem_wr_valid, .mem_wr, .mem_wr_ready, .apic_wr_valid, .apic_wr,
	.port_eoi_disable, .eoi_msg_valid);

// ### sim/hir_far_model.sv
`timescale 1ns/1ns
module hir_far_model #(
	parameter logic [7:0] VEC = 8'h5A
) (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       stall,
	input  wire logic       interrupt_acknowledge_cycle,
	output logic            int_msg_ready,
	output logic            mem_wr_ready,
	output logic            apic_wr_ready,
	output logic            iack_resp_valid,
	output logic [7:0]      iack_resp_vector
);
	// Processor buses and downstream agents stall together on command
	assign int_msg_ready = !stall;
	assign mem_wr_ready  = !stall;
	assign apic_wr_ready = !stall;

	// Compatibility hub answers an acknowledge cycle one clock later
	always_ff @(posedge clk) begin
		iack_resp_valid <= rst ? 1'h0 : interrupt_acknowledge_cycle;
		// Vector scrambled outside its pulse so stale data never matches
		iack_resp_vector <= interrupt_acknowledge_cycle ? VEC : ~VEC;
	end
endmodule

// ### sim/hir_router_tb.sv
`timescale 1ns/1ns
module hir_router_tb
	import hir_pkg::*;
();
	localparam logic [7:0] VEC = 8'h5A;
	logic          clk, rst, ce, fsb_req_valid, target_ready_n, no_data_resp, stall;
	logic          priority_bus_request_n, fsb_data_valid, int_msg_valid, int_msg_ready;
	logic          ib_wr_valid, ib_wr_ready, mem_wr_valid, mem_wr_ready, apic_wr_valid;
	logic          apic_wr_ready, interrupt_acknowledge_cycle, iack_resp_valid, intx_valid;
	logic [7:0]    fsb_data, redir_choice_id, eoi_vector, iack_resp_vector;
	logic [3:0]    port_eoi_disable, eoi_msg_valid, legacy_int_level;
	logic [11:0]   ev;
	logic [31:0]   apic_id_enabled;
	hir_fsb_req_t  fsb_req;
	hir_int_msg_t  int_msg, m;
	hir_ib_wr_t    ib_wr, mem_wr, apic_wr;
	hir_intx_msg_t intx;
	int            n_errors = 0, total_checks = 0, cyc = 0;

	hir_router u_hir_router (.clk, .rst, .ce, .fsb_req_valid, .fsb_req, .target_ready_n,
		.no_data_resp, .priority_bus_request_n, .fsb_data_valid, .fsb_data, .apic_id_enabled,
		.redir_choice_id, .int_msg_valid, .int_msg, .int_msg_ready, .ib_wr_valid, .ib_wr,
		.ib_wr_ready, .mem_wr_valid, .mem_wr, .mem_wr_ready, .apic_wr_valid, .apic_wr,
		.apic_wr_ready, .port_eoi_disable, .eoi_msg_valid, .eoi_vector,
		.interrupt_acknowledge_cycle, .iack_resp_valid, .iack_resp_vector, .intx_valid,
		.intx, .legacy_int_level);
	hir_far_model #(.VEC(VEC)) u_hir_far_model (.clk, .rst, .stall,
		.interrupt_acknowledge_cycle, .int_msg_ready, .mem_wr_ready, .apic_wr_ready,
		.iack_resp_valid, .iack_resp_vector);

	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	// Hang guard, well above the hundred or so cycles the tests need
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_errors++;
			give_verdict();
		end
	end

	task automatic chk(input logic [39:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task give_verdict();
		$display("checks=%0d errors=%0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic req(input hir_kind_t k, input logic [1:0] sb, input logic h, dm,
			input logic [7:0] d);
		@(posedge clk);
		fsb_req <= '{k, sb, h, dm, d, 8'h41};
		fsb_req_valid <= 1'h1;
	endtask

	// Waits for the claim, samples what comes with it, then drops the request
	task automatic claim(input logic nd);
		for (int i = 0; i < 50 && target_ready_n !== 1'h0; i++) @(negedge clk);
		chk({target_ready_n, no_data_resp, fsb_data_valid}, {1'h0, nd, !nd});
		if (!nd) chk(fsb_data, VEC);
		m = int_msg;
		ev = {eoi_msg_valid, eoi_vector};
		@(posedge clk);
		fsb_req_valid <= 1'h0;
	endtask

	task automatic ipi(input logic [1:0] sb, input logic h, dm, input logic [7:0] d);
		req(HIR_K_INT, sb, h, dm, d);
		claim(1'h1);
	endtask

	task automatic push(input logic [1:0] p, input logic [31:0] a, d);
		ib_wr <= '{p, a, d};
		ib_wr_valid <= 1'h1;
		@(posedge clk);
		while (ib_wr_ready !== 1'h1) @(posedge clk);
	endtask

	task automatic t_ipi();
		ipi(2'h1, 1'h0, 1'h0, 8'h02);
		chk(m, {4'hD, 2'h0, 8'h02, 8'h41});
		ipi(2'h2, 1'h0, 1'h1, 8'hFF);
		chk(m, {4'hB, 2'h1, 8'hFF, 8'h41});
		ipi(2'h0, 1'h1, 1'h1, 8'h03);
		chk(m, {4'hF, 2'h1, 8'h07, 8'h41});
		ipi(2'h3, 1'h1, 1'h0, 8'h02);
		chk(m, {4'hF, 2'h0, 8'h02, 8'h41});
		$display("t_ipi done");
	endtask

	task automatic t_eoi_iack();
		port_eoi_disable <= 4'h4;
		req(HIR_K_EOI, 2'h0, 1'h0, 1'h0, 8'h00);
		claim(1'h1);
		chk(ev, {4'hB, 8'h41});
		req(HIR_K_IACK, 2'h1, 1'h0, 1'h0, 8'h00);
		for (int i = 0; i < 20 && interrupt_acknowledge_cycle !== 1'h1; i++) @(negedge clk);
		chk(interrupt_acknowledge_cycle, 1'h1);
		claim(1'h0);
		$display("t_eoi_iack done");
	endtask

	// Second interrupt finds the message stage full and must wait, not retry
	task automatic t_stall();
		stall <= 1'h1;
		ipi(2'h0, 1'h0, 1'h0, 8'h01);
		req(HIR_K_INT, 2'h1, 1'h0, 1'h0, 8'h01);
		repeat (3) @(negedge clk);
		chk({priority_bus_request_n, target_ready_n}, 2'h1);
		@(posedge clk);
		stall <= 1'h0;
		claim(1'h1);
		$display("t_stall done");
	endtask

	task automatic t_inbound();
		@(posedge clk);
		stall <= 1'h1;
		push(2'h1, 32'h0000_1000, 32'hCAFE_0001);
		push(2'h1, 32'hFEE0_1000, 32'h0000_0041);
		push(2'h0, 32'hFEC0_2020, 32'h0000_0052);
		ib_wr_valid <= 1'h0;
		repeat (4) @(negedge clk);
		chk({mem_wr_valid, int_msg_valid, mem_wr.addr}, {2'h2, 32'h0000_1000});
		chk(mem_wr.data, 32'hCAFE_0001);
		@(posedge clk);
		stall <= 1'h0;
		for (int i = 0; i < 20 && int_msg_valid !== 1'h1; i++) @(negedge clk);
		chk(int_msg, {4'hF, 2'h0, 8'h01, 8'h41});
		for (int i = 0; i < 20 && apic_wr_valid !== 1'h1; i++) @(negedge clk);
		chk({apic_wr.port, apic_wr.addr}, {2'h2, 32'hFEC0_2020});
		chk(apic_wr.data, 32'h0000_0052);
		$display("t_inbound done");
	endtask

	// Edge source sends once with no end-of-interrupt; a level source still
	// asserted resends after one, here as a hinted logical message
	task automatic t_resend();
		@(posedge clk);
		port_eoi_disable <= 4'h0;
		push(2'h0, 32'hFEE0_2000, 32'h0000_0033);
		ib_wr_valid <= 1'h0;
		for (int i = 0; i < 20 && int_msg_valid !== 1'h1; i++) @(negedge clk);
		chk(int_msg, {4'hF, 2'h0, 8'h02, 8'h33});
		req(HIR_K_EOI, 2'h2, 1'h0, 1'h0, 8'h00);
		claim(1'h1);
		chk(ev, {4'hF, 8'h41});
		push(2'h3, 32'hFEE0_300C, 32'h0000_0041);
		ib_wr_valid <= 1'h0;
		for (int i = 0; i < 20 && int_msg_valid !== 1'h1; i++) @(negedge clk);
		chk(int_msg, {4'hF, 2'h1, 8'h07, 8'h41});
		$display("t_resend done");
	endtask

	task automatic t_legacy();
		for (int j = 1; j >= 0; j--) begin
			@(posedge clk);
			intx <= '{2'h1, 2'h2, j[0]};
			intx_valid <= 1'h1;
			@(posedge clk);
			intx_valid <= 1'h0;
			@(posedge clk);
			@(negedge clk);
			chk(legacy_int_level, {1'h0, j[0], 2'h0});
		end
		$display("t_legacy done");
	endtask

	// Clock enable low freezes every stage, so a legacy pulse then is lost
	task automatic t_freeze();
		@(posedge clk);
		ce <= 1'h0;
		intx <= '{2'h3, 2'h0, 1'h1};
		intx_valid <= 1'h1;
		@(posedge clk);
		intx_valid <= 1'h0;
		repeat (2) @(posedge clk);
		ce <= 1'h1;
		repeat (2) @(negedge clk);
		chk(legacy_int_level, 4'h0);
		$display("t_freeze done");
	endtask

	// Main sequence; clock enable stays high except while t_freeze drops it
	initial begin
		{rst, ce, fsb_req_valid, ib_wr_valid, intx_valid, stall} = 6'h30;
		fsb_req = '0;
		ib_wr = '0;
		intx = '0;
		apic_id_enabled = 32'h0000_0004;
		redir_choice_id = 8'h07;
		port_eoi_disable = 4'h0;
		repeat (20) @(posedge clk);
		rst <= 1'h0;
		repeat (2) @(posedge clk);
		t_ipi();
		t_eoi_iack();
		t_stall();
		t_inbound();
		t_resend();
		t_legacy();
		t_freeze();
		give_verdict();
	end
endmodule
